// >>> bench/svid_host_model.sv
`timescale 1ns/1ps
module svid_host_model (
  output logic      sclk,
  output logic      sdioLow,
  input  wire logic sdioWire
);
  // ------------------------------------------------------------
  // idle bus: clock parked high, data released to the pull-up
  // ------------------------------------------------------------
  initial begin
    sclk = 1'b1;
    sdioLow = 1'b0;
  end

  // ------------------------------------------------------------
  // frame send and ack capture
  // ------------------------------------------------------------
  task automatic sendFrame(input logic [3:0] a, input logic [4:0] c,
                           input logic [7:0] d, input logic badPar,
                           output logic [1:0] ack);
    logic [23:0] f;
    f = {3'b010, a, c, d, ^{a, c, d} ^ badPar, 3'b011};
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      sdioLow = ~f[i];
      #100;
      sclk = 1'b1;
      #100;
    end
    sdioLow = 1'b0;
    for (int k = 0; k < 6; k++) begin
      sclk = 1'b0;
      #100;
      sclk = 1'b1;
      #100;
      // ack bits settle late: take each at the end of its period
      if (k == 0) ack[1] = sdioWire;
      if (k == 1) ack[0] = sdioWire;
    end
  endtask
endmodule

// >>> bench/vr_power_state_and_fault_control_test.sv
`timescale 1ns/1ps
module vr_power_state_and_fault_control_test
  import vr_ctrl_pkg::*;
;
  logic        clk;
  logic        reset;
  logic        sclk;
  logic        sdioLow;
  logic        sdioOut;
  logic        sdioOe;
  logic        alertOut;
  logic        alertOe;
  logic        enablePin;
  logic        ocLowCmp;
  logic        ocFastCmp;
  logic [10:0] strapMv;
  logic [7:0]  regAddr;
  logic [7:0]  regWdata;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdata;
  logic        irq;
  logic [7:0]  vidOut;
  logic        forcedCcm;
  logic        autoDcm;
  logic        outputOff;
  logic        ocpFault;
  logic [7:0]  rv;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  wire         sdioWire = ~(sdioLow | (sdioOe & ~sdioOut));

  vr_power_state_and_fault_control dut_u (
    .clk(clk), .reset(reset), .sclkIn(sclk), .sdioIn(sdioWire),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .alertOut(alertOut),
    .alertOe(alertOe), .enablePin(enablePin), .ocLowCmp(ocLowCmp),
    .ocFastCmp(ocFastCmp), .strapMv(strapMv), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .vidOut(vidOut),
    .forcedCcm(forcedCcm), .autoDcm(autoDcm), .outputOff(outputOff),
    .ocpFault(ocpFault));

  svid_host_model host_u (.sclk(sclk), .sdioLow(sdioLow),
                          .sdioWire(sdioWire));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      results();
    end
  end

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask

  task automatic frame(input logic [4:0] c, input logic [7:0] d,
                       input logic [1:0] e, input logic [3:0] a = 4'h0);
    logic [1:0] k;
    host_u.sendFrame(a, c, d, 1'b0, k);
    chk({6'h0, k}, {6'h0, e});
  endtask

  task automatic waitVid(input logic [7:0] e);
    int n;
    n = 0;
    while (vidOut !== e && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(vidOut, e);
  endtask

  task automatic gap(input int e);
    logic [7:0] v;
    int         n;
    for (int j = 0; j < 2; j++) begin
      v = vidOut;
      n = 0;
      while (vidOut === v && n < 2000) begin
        @(posedge clk);
        #1;
        n++;
      end
    end
    chk(n[7:0], e[7:0]);
  endtask

  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    enablePin = 1'b0;
    ocLowCmp = 1'b0;
    ocFastCmp = 1'b0;
    strapMv = 11'd836;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    cyc(10);
    reset <= 1'b0;
    rdc(REG_STRAP, 8'h10);
    strapMv <= 11'd0;
    rdc(REG_SR_FAST, SR_FAST_RST);
    wr(REG_SR_FAST, 8'h00);
    rdc(REG_SR_FAST, SR_FAST_RST);
    rdc(REG_SR_SEL, {6'h0, SR_SEL_RST});
    rdc(REG_MASK, {4'h0, MASK_RST});
    rdc(REG_VOUT_MAX, VOUT_MAX_RST);
    rdc(8'h40, 8'h00);
    rdc(REG_STRAP, 8'h10);
    $display("test registers done");

    enablePin <= 1'b1;
    waitVid(VID_BOOT_HI);
    chk({7'h0, forcedCcm}, 8'h01);
    wr(REG_MASK, 8'h0f);
    rd(REG_STATUS);
    frame(CMD_VID_FAST, 8'h80, ACK_OK);
    gap(FAST_STEP_CYC);
    waitVid(8'h80);
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    chk({6'h0, alertOut, alertOe}, 8'h01);
    rdc(REG_STATUS, 8'h05);
    cyc(2);
    chk({6'h0, irq, alertOe}, 8'h00);
    $display("test fast ramp done");

    for (int s = 0; s < 4; s++) begin
      wr(REG_SR_SEL, s[7:0]);
      frame(CMD_VID_SLOW, (s % 2 == 0) ? 8'h90 : 8'h80, ACK_OK);
      gap(FAST_STEP_CYC << (s + 1));
      waitVid((s % 2 == 0) ? 8'h90 : 8'h80);
    end
    $display("test slow ramp done");

    rd(REG_STATUS);
    wr(REG_MASK, 8'h01);
    frame(CMD_VID_FAST, 8'hb6, ACK_REJECT);
    cyc(3);
    chk({7'h0, irq}, 8'h00);
    rdc(REG_STATUS, 8'h02);
    frame(5'h00, 8'h40, ACK_REJECT);
    frame(5'h05, 8'h40, ACK_REJECT);
    frame(CMD_VID_FAST, 8'h70, 2'b11, 4'h1);
    chk(vidOut, 8'h80);
    frame(CMD_VID_DECAY, 8'h40, ACK_OK);
    chk(vidOut, 8'h40);
    frame(CMD_VID_DECAY, 8'h50, ACK_REJECT);
    $display("test commands done");

    for (int p = 0; p < 5; p++) begin
      frame(CMD_SET_PS, p[7:0], ACK_OK);
      cyc(5);
      chk({5'h0, forcedCcm, autoDcm, outputOff},
          {5'h0, p < 2, p == 2 || p == 3, p == 4});
    end
    chk(vidOut, 8'h00);
    frame(CMD_SET_PS, 8'h05, ACK_REJECT);
    frame(CMD_SET_PS, 8'h00, ACK_OK);
    $display("test power states done");

    ocLowCmp <= 1'b1;
    cyc(1000);
    ocLowCmp <= 1'b0;
    cyc(10);
    chk({7'h0, ocpFault}, 8'h00);
    ocLowCmp <= 1'b1;
    cyc(1990);
    chk({7'h0, ocpFault}, 8'h00);
    cyc(20);
    chk({6'h0, ocpFault, outputOff}, 8'h03);
    ocLowCmp <= 1'b0;
    cyc(20);
    chk({7'h0, ocpFault}, 8'h01);
    frame(CMD_SET_PS, 8'h00, ACK_REJECT);
    enablePin <= 1'b0;
    cyc(10);
    enablePin <= 1'b1;
    cyc(10);
    chk({7'h0, ocpFault}, 8'h00);
    ocFastCmp <= 1'b1;
    cyc(6);
    chk({7'h0, ocpFault}, 8'h01);
    ocFastCmp <= 1'b0;
    $display("test overcurrent done");

    reset <= 1'b1;
    strapMv <= 11'd835;
    cyc(3);
    reset <= 1'b0;
    rdc(REG_STRAP, 8'h08);
    $display("test strap done");
    results();
  end
endmodule

// >>> hw/vr_ctrl_pkg.sv
package vr_ctrl_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 40;
  localparam int OCP_TIMER_US    = 50;
  localparam int OCP_TIMER_CYC   = OCP_TIMER_US * CLK_MHZ;
  localparam int VID_STEP_MV     = 5;

  // ----------------------------------------------------------------
  // slew rates
  // ----------------------------------------------------------------
  localparam logic [7:0] SR_FAST_RST  = 8'h32;
  localparam logic [1:0] SR_SEL_RST   = 2'h1;
  localparam int FAST_STEP_CYC =
    (VID_STEP_MV * CLK_MHZ + int'(SR_FAST_RST) - 1) / int'(SR_FAST_RST);

  // ----------------------------------------------------------------
  // link frame layout and commands
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS = 24;
  localparam logic [2:0]  FRM_START  = 3'h2;
  localparam logic [2:0]  FRM_END    = 3'h3;
  localparam logic [4:0]  CMD_VID_FAST  = 5'h01;
  localparam logic [4:0]  CMD_VID_SLOW  = 5'h02;
  localparam logic [4:0]  CMD_VID_DECAY = 5'h03;
  localparam logic [4:0]  CMD_SET_PS    = 5'h04;
  localparam logic [1:0]  ACK_OK     = 2'h0;
  localparam logic [1:0]  ACK_REJECT = 2'h1;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  localparam logic [2:0] PS_NORMAL = 3'h0;
  localparam logic [2:0] PS_LOW    = 3'h1;
  localparam logic [2:0] PS_VLOW   = 3'h2;
  localparam logic [2:0] PS_ULOW   = 3'h3;
  localparam logic [2:0] PS_OFF    = 3'h4;

  // ----------------------------------------------------------------
  // boot strap decode
  // ----------------------------------------------------------------
  localparam int          STRAP_BANDS  = 17;
  localparam int          BANDS_HALF   = 9;
  localparam logic [7:0]  VID_BOOT_LO  = 8'h97;
  localparam logic [7:0]  VID_BOOT_HI  = 8'hfb;
  localparam logic [10:0] STRAP_EDGE_MV [STRAP_BANDS] = '{
    11'd102, 11'd180, 11'd258, 11'd344, 11'd438, 11'd531,
    11'd625, 11'd727, 11'd836, 11'd953, 11'd1062, 11'd1188,
    11'd1312, 11'd1445, 11'd1578, 11'd1719, 11'd1859};

  // ----------------------------------------------------------------
  // local register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_MASK     = 8'h04;
  localparam logic [7:0] REG_SR_FAST  = 8'h08;
  localparam logic [7:0] REG_SR_SEL   = 8'h0c;
  localparam logic [7:0] REG_VID_TGT  = 8'h10;
  localparam logic [7:0] REG_VID_REF  = 8'h14;
  localparam logic [7:0] REG_PSTATE   = 8'h18;
  localparam logic [7:0] REG_STRAP    = 8'h1c;
  localparam logic [7:0] REG_VOUT_MAX = 8'h20;
  localparam logic [7:0] REG_FAULT    = 8'h24;
  localparam logic [7:0] VOUT_MAX_RST = 8'hb5;
  localparam logic [3:0] MASK_RST     = 4'h0;

  localparam int EV_ACCEPT = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_SETTLE = 2;
  localparam int EV_OCP    = 3;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01,
    ACK_BIT0 = 2'b11,
    ACK_BIT1 = 2'b10
  } ack_state_t;

endpackage

// >>> hw/vr_power_state_and_fault_control.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
// Functional notes
// - five power states; first two forced ccm, next two auto ccm/dcm
// - fifth state holds output at zero, only link stays active
// - forced ccm keeps continuous current at resistor-set frequency
// - auto modes drop into pulse-frequency operation at light load
// - link uses three open-drain wires pulled up to cpu rail
// - host keeps link clock under its maximum; device follows it
// - command 01h ramps at fast rate, 02h at fast rate divided
// - command 03h moves target down with no controlled slew
// - strap below 836 mV boots 1.0 V, otherwise 1.5 V
// - strap band within each half selects bus address 0 to 8
// - boot voltage and address latched once, later strap ignored
// - lower limit starts latch-off timer; persistence shuts down
// - fast limit trip shuts down at once
// - shutdown stays latched until enable cycles low then high
// - fast slew rate readable in a read-only register
module vr_power_state_and_fault_control
  import vr_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        sclkIn,
  input  wire logic        sdioIn,
  output logic             sdioOut,
  output logic             sdioOe,
  output logic             alertOut,
  output logic             alertOe,
  input  wire logic        enablePin,
  input  wire logic        ocLowCmp,
  input  wire logic        ocFastCmp,
  input  wire logic [10:0] strapMv,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdata,
  output logic             irq,
  output logic [7:0]       vidOut,
  output logic             forcedCcm,
  output logic             autoDcm,
  output logic             outputOff,
  output logic             ocpFault
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] strapBand(input logic [10:0] mv);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < STRAP_BANDS; i++) begin
      if (mv >= STRAP_EDGE_MV[i]) begin
        n = n + 5'h1;
      end
    end
    return n;
  endfunction

  function automatic logic [7:0] stepLenOf(input logic [4:0] cmd,
                                           input logic [1:0] sel);
    logic [7:0] len;
    len = 8'(FAST_STEP_CYC);
    if (cmd == CMD_VID_SLOW) begin
      // widened so the /16 setting does not wrap to zero
      len = 8'(FAST_STEP_CYC << ({1'b0, sel} + 3'h1));
    end
    return len;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] syncA_r;
  logic [4:0] syncB_r;
  logic       sclkDly_r;
  logic       sclkS;
  logic       sdioS;
  logic       enS;
  logic       ocLowS;
  logic       ocFastS;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // idle level of the pulled-up link pins, no false edge
      syncA_r   <= 5'h03;
      syncB_r   <= 5'h03;
      sclkDly_r <= 1'b1;
    end else begin
      syncA_r   <= {ocFastCmp, ocLowCmp, enablePin, sdioIn, sclkIn};
      syncB_r   <= syncA_r;
      sclkDly_r <= syncB_r[0];
    end
  end

  assign sclkS   = syncB_r[0];
  assign sdioS   = syncB_r[1];
  assign enS     = syncB_r[2];
  assign ocLowS  = syncB_r[3];
  assign ocFastS = syncB_r[4];

  logic sclkRise;
  logic sclkFall;
  assign sclkRise = sclkS & ~sclkDly_r;
  assign sclkFall = ~sclkS & sclkDly_r;

  // ----------------------------------------------------------------
  // strap capture and enable tracking
  // ----------------------------------------------------------------
  logic       strapDone_r;
  logic [3:0] busAddr_r;
  logic       bootHigh_r;
  logic       enDly_r;
  logic [4:0] band;
  assign band = strapBand(strapMv);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strapDone_r <= 1'b0;
      busAddr_r   <= 4'h0;
      bootHigh_r  <= 1'b0;
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      bootHigh_r  <= band >= 5'(BANDS_HALF);
      busAddr_r   <= 4'(band >= 5'(BANDS_HALF) ? band - 5'(BANDS_HALF)
                                                : band);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enDly_r <= 1'b0;
    end else begin
      enDly_r <= enS;
    end
  end

  // ----------------------------------------------------------------
  // link frame receive and acknowledge
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_r;
  ack_state_t            ackState_r;
  logic [1:0]            ackCode_r;
  logic [4:0]            frmCmd;
  logic [7:0]            frmData;
  logic                  frmOk;
  logic                  accept;
  logic                  reject;
  logic [7:0]            voutMax_r;
  logic [7:0]            vidRef_r;
  logic                  faultLat_r;

  assign frmCmd  = shift_r[16:12];
  assign frmData = shift_r[11:4];
  // framed command with parity and our address
  assign frmOk = shift_r[23:21] == FRM_START && shift_r[2:0] == FRM_END
              && shift_r[20:17] == busAddr_r && strapDone_r
              && (^shift_r[20:4]) == shift_r[3]
              && ackState_r == ACK_IDLE;
  assign reject = frmOk && (faultLat_r || !enS
              || frmCmd == 5'h0 || frmCmd > CMD_SET_PS
              || (frmCmd != CMD_SET_PS && frmData > voutMax_r)
              || (frmCmd == CMD_SET_PS && frmData[7:3] != 5'h0)
              || (frmCmd == CMD_SET_PS && frmData[2:0] > PS_OFF)
              || (frmCmd == CMD_VID_DECAY && frmData > vidRef_r));
  assign accept = frmOk && !reject;

  // sampling on sync'd edges of the link clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_r <= '0;
    end else if (frmOk) begin
      shift_r <= '0;
    end else if (sclkRise && ackState_r == ACK_IDLE) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], sdioS};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ackState_r <= ACK_IDLE;
      ackCode_r  <= ACK_OK;
    end else begin
      case (ackState_r)
        ACK_IDLE: begin
          if (frmOk) begin
            ackState_r <= ACK_WAIT;
            ackCode_r  <= reject ? ACK_REJECT : ACK_OK;
          end
        end
        ACK_WAIT: if (sclkFall) ackState_r <= ACK_BIT0;
        ACK_BIT0: if (sclkFall) ackState_r <= ACK_BIT1;
        ACK_BIT1: if (sclkFall) ackState_r <= ACK_IDLE;
        default:  ackState_r <= ACK_IDLE;
      endcase
    end
  end

  // open drain: only ever pull low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdioOut <= 1'b0;
      sdioOe  <= 1'b0;
    end else begin
      sdioOut <= 1'b0;
      sdioOe  <= (ackState_r == ACK_BIT0 && !ackCode_r[1])
              || (ackState_r == ACK_BIT1 && !ackCode_r[0]);
    end
  end

  // ----------------------------------------------------------------
  // power state and target
  // ----------------------------------------------------------------
  logic [2:0] pState_r;
  logic [7:0] vidTgt_r;
  logic [7:0] stepLen_r;
  logic [7:0] stepCnt_r;
  logic [1:0] srSel_r;
  logic       ramping_r;
  logic       settle;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pState_r <= PS_NORMAL;
    end else if (!enS) begin
      pState_r <= PS_NORMAL;
    end else if (accept && frmCmd == CMD_SET_PS) begin
      pState_r <= frmData[2:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vidTgt_r  <= 8'h0;
      stepLen_r <= 8'(FAST_STEP_CYC);
    end else if (!enS || faultLat_r) begin
      vidTgt_r  <= 8'h0;
    end else if (enS && !enDly_r) begin
      vidTgt_r  <= bootHigh_r ? VID_BOOT_HI : VID_BOOT_LO;
      stepLen_r <= 8'(FAST_STEP_CYC);
    end else if (accept && frmCmd != CMD_SET_PS) begin
      vidTgt_r  <= frmData;
      stepLen_r <= stepLenOf(frmCmd, srSel_r);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vidRef_r  <= 8'h0;
      stepCnt_r <= 8'h0;
      ramping_r <= 1'b0;
    end else if (!enS || faultLat_r) begin
      vidRef_r  <= 8'h0;
      stepCnt_r <= 8'h0;
      ramping_r <= 1'b0;
    end else if (accept && frmCmd == CMD_VID_DECAY) begin
      vidRef_r  <= frmData;
      ramping_r <= 1'b0;
    end else if (vidRef_r != vidTgt_r) begin
      ramping_r <= 1'b1;
      if (stepCnt_r == 8'h0) begin
        stepCnt_r <= stepLen_r - 8'h1;
        vidRef_r  <= vidRef_r < vidTgt_r ? vidRef_r + 8'h1
                                         : vidRef_r - 8'h1;
      end else begin
        stepCnt_r <= stepCnt_r - 8'h1;
      end
    end else begin
      stepCnt_r <= 8'h0;
      ramping_r <= 1'b0;
    end
  end

  assign settle = ramping_r && vidRef_r == vidTgt_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      forcedCcm <= 1'b1;
      autoDcm   <= 1'b0;
      outputOff <= 1'b1;
      vidOut    <= 8'h0;
    end else begin
      forcedCcm <= pState_r == PS_NORMAL || pState_r == PS_LOW;
      autoDcm   <= pState_r == PS_VLOW || pState_r == PS_ULOW;
      // zero output in the off state
      outputOff <= pState_r == PS_OFF || faultLat_r || !enS;
      vidOut    <= (pState_r == PS_OFF) ? 8'h0 : vidRef_r;
    end
  end

  // ----------------------------------------------------------------
  // overcurrent
  // ----------------------------------------------------------------
  logic [11:0] ocTimer_r;
  logic        ocTrip;

  assign ocTrip = enS && !faultLat_r && (ocFastS
               || (ocLowS && ocTimer_r == 12'(OCP_TIMER_CYC - 1)));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ocTimer_r <= 12'h0;
    end else if (!ocLowS || faultLat_r || !enS) begin
      ocTimer_r <= 12'h0;
    end else begin
      ocTimer_r <= ocTimer_r + 12'h1;
    end
  end

  // fast or timer trip; held until enable low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      faultLat_r <= 1'b0;
    end else if (!enS) begin
      faultLat_r <= 1'b0;
    end else if (ocTrip) begin
      faultLat_r <= 1'b1;
    end
  end

  assign ocpFault = faultLat_r;

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [3:0] events;
  assign events = {ocTrip, settle, reject, accept};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_r    <= MASK_RST;
      srSel_r   <= SR_SEL_RST;
      voutMax_r <= VOUT_MAX_RST;
    end else if (regWr) begin
      if (regAddr == REG_MASK)     mask_r    <= regWdata[3:0];
      if (regAddr == REG_SR_SEL)   srSel_r   <= regWdata[1:0];
      if (regAddr == REG_VOUT_MAX) voutMax_r <= regWdata;
    end
  end

  // read clears; a same-cycle event wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r <= 4'h0;
    end else begin
      status_r <= (regRd && regAddr == REG_STATUS ? 4'h0 : status_r)
                | events;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdata <= 8'h0;
    end else if (regRd) begin
      case (regAddr)
        REG_STATUS:   regRdata <= {4'h0, status_r};
        REG_MASK:     regRdata <= {4'h0, mask_r};
        REG_SR_FAST:  regRdata <= SR_FAST_RST;
        REG_SR_SEL:   regRdata <= {6'h0, srSel_r};
        REG_VID_TGT:  regRdata <= vidTgt_r;
        REG_VID_REF:  regRdata <= vidRef_r;
        REG_PSTATE:   regRdata <= {5'h0, pState_r};
        REG_STRAP:    regRdata <= {3'h0, bootHigh_r, busAddr_r};
        REG_VOUT_MAX: regRdata <= voutMax_r;
        REG_FAULT:    regRdata <= {7'h0, faultLat_r};
        default:      regRdata <= 8'h0;
      endcase
    end else begin
      regRdata <= 8'h0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq      <= 1'b0;
      alertOut <= 1'b0;
      alertOe  <= 1'b0;
    end else begin
      irq      <= |(status_r & mask_r);
      alertOut <= 1'b0;
      alertOe  <= status_r[EV_SETTLE] | status_r[EV_OCP];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  fast_trip_a: assert property (ocFastS && enS && !faultLat_r
    |=> faultLat_r) else $error("fast trip missed");
  fault_hold_a: assert property (faultLat_r && enS |=> faultLat_r)
    else $error("fault released early");
  timer_clear_a: assert property (!ocLowS |=> ocTimer_r == 12'h0)
    else $error("timer not cleared");
  timer_trip_a: assert property (ocLowS && enS && !faultLat_r
    && !ocFastS && ocTimer_r == 12'h0 |-> !faultLat_r [*8])
    else $error("latched before timer");
  off_zero_a: assert property (pState_r == PS_OFF |=> vidOut == 8'h0)
    else $error("vid not zero in off state");
  mode_map_a: assert property (##1 forcedCcm == ($past(pState_r) < PS_VLOW))
    else $error("ccm mode mismatch");
  step_one_a: assert property (enS && !faultLat_r && !accept
    |=> vidRef_r - $past(vidRef_r) inside {8'h0, 8'h1, 8'hff}
        || !enS || faultLat_r)
    else $error("reference jumped");
  decay_jump_a: assert property (accept && frmCmd == CMD_VID_DECAY
    && enS |=> vidRef_r == $past(frmData) || !enS)
    else $error("decay not applied");
  strap_lock_a: assert property (strapDone_r |=> $stable(busAddr_r)
    && $stable(bootHigh_r)) else $error("strap relatched");
  sr_read_a: assert property (regRd && regAddr == REG_SR_FAST
    |=> regRdata == SR_FAST_RST) else $error("slew readback");
  sdio_drive_a: assert property (sdioOe |-> $past(ackState_r) inside
    {ACK_BIT0, ACK_BIT1} && !sdioOut)
    else $error("sdio driven outside ack");

  accept_c: cover property (accept ##[1:200] settle);
  ocp_c:    cover property (ocLowS && enS ##1 faultLat_r);
  ps4_c:    cover property (accept && frmCmd == CMD_SET_PS
                            && frmData == 8'h04);

endmodule
